// File: verilog/sqf_pkg.sv
// Overview of operation
// - Empty rises when enabled queue is unfilled, last entry read, or cleared.
// - Empty is held at one while the queue is disabled; resets to one.
// - Empty drops to zero whenever at least one entry is stored.
// - Empty interrupt follows the empty flag in the same cycles.
// - Limit checks only for results of channels with compare enabled.
// - Upper hit sets when enabled result is at or above upper limit field.
// - Lower hit sets when enabled result is at or below lower limit field.
// - Limit register at 0x3C, resets to 0xFFF000, both fields read/write.
// - Host reads queue contents through read-only data port at 0x3D.
// - Limit hit flags clear when the queue becomes empty.
package sqf_pkg;
    localparam int SQF_ADDR_W = 8;
    localparam int SQF_DATA_W = 24;
    localparam int SQF_SAMPLE_W = 16;
    localparam int SQF_LIMIT_W = 12;
    localparam int SQF_CHAN_W = 4;

    localparam logic [SQF_ADDR_W-1:0] SQF_LIMIT_ADDR = 8'h3C;
    localparam logic [SQF_ADDR_W-1:0] SQF_READ_ADDR = 8'h3D;
    localparam logic [SQF_DATA_W-1:0] SQF_LIMIT_RESET = 24'hFFF000;
    localparam logic [SQF_SAMPLE_W-1:0] SQF_READ_RESET = 16'h0000;
    localparam logic SQF_EMPTY_RESET = 1'h1;

    localparam int SQF_UPPER_LSB = 12;
    localparam int SQF_UPPER_MSB = 23;
    localparam int SQF_LOWER_LSB = 0;
    localparam int SQF_LOWER_MSB = 11;
    // Result bits compared against the 12-bit limits
    localparam int SQF_CMP_LSB = 4;

    typedef struct packed {
        logic [SQF_CHAN_W-1:0] chan;
        logic [SQF_SAMPLE_W-1:0] data;
    } sqf_sample_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [SQF_ADDR_W-1:0] addr;
        logic [SQF_DATA_W-1:0] wdata;
    } sqf_reg_req_s;

    function automatic logic [SQF_LIMIT_W-1:0] sqf_upper(
        input logic [SQF_DATA_W-1:0] r);
        return r[SQF_UPPER_MSB:SQF_UPPER_LSB];
    endfunction

    function automatic logic [SQF_LIMIT_W-1:0] sqf_lower(
        input logic [SQF_DATA_W-1:0] r);
        return r[SQF_LOWER_MSB:SQF_LOWER_LSB];
    endfunction

    function automatic logic [SQF_LIMIT_W-1:0] sqf_cmp_bits(
        input logic [SQF_SAMPLE_W-1:0] d);
        return d[SQF_CMP_LSB+SQF_LIMIT_W-1:SQF_CMP_LSB];
    endfunction
endpackage

// File: verilog/sqf_queue.sv
`timescale 1ns/1ns
module sqf_queue #(
    parameter int DEPTH = 256,
    parameter int CHANNELS = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Queue control
    input wire logic i_queue_enable,
    input wire logic i_queue_clear,
    input wire logic [CHANNELS-1:0] i_per_channel_compare_enable,
    // Conversion results
    input wire logic i_sample_valid,
    input wire sqf_pkg::sqf_sample_s i_sample,
    // Register access from the serial interface
    input wire sqf_pkg::sqf_reg_req_s i_reg_req,
    output logic [sqf_pkg::SQF_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Status
    output logic o_empty_flag,
    output logic o_empty_irq,
    output logic o_upper_limit_hit,
    output logic o_lower_limit_hit,
    output logic o_full
);
    import sqf_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST_PTR) ? '0 : p + AW'(1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage
    sqf_sample_s mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic [SQF_DATA_W-1:0] limits, next_limits;
    logic [SQF_DATA_W-1:0] next_rdata;
    logic next_rvalid;
    logic next_empty, next_full;
    logic next_upper, next_lower;
    logic push, pop, flush, cmp_en;
    logic [SQF_LIMIT_W-1:0] cmp_val;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        flush = i_queue_clear || !i_queue_enable;
        pop = i_reg_req.rd && (i_reg_req.addr == SQF_READ_ADDR)
            && (count != '0) && !flush;
        push = i_sample_valid && i_queue_enable && !i_queue_clear
            && ((count != FULL_COUNT) || pop);
        cmp_en = i_per_channel_compare_enable[i_sample.chan];
        cmp_val = sqf_cmp_bits(i_sample.data);

        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end else begin
            if (push) begin
                next_wr_ptr = bump(wr_ptr);
            end
            if (pop) begin
                next_rd_ptr = bump(rd_ptr);
            end
            if (push && !pop) begin
                next_count = count + CW'(1);
            end else if (pop && !push) begin
                next_count = count - CW'(1);
            end
        end
        next_full = (next_count == FULL_COUNT);
        // Covers disabled, unfilled, last read and clear
        next_empty = (next_count == '0);

        next_upper = o_upper_limit_hit;
        next_lower = o_lower_limit_hit;
        if (next_empty) begin
            next_upper = 1'b0;
            next_lower = 1'b0;
        end
        if (push && cmp_en) begin
            if (cmp_val >= sqf_upper(limits)) begin
                next_upper = 1'b1;
            end
            if (cmp_val <= sqf_lower(limits)) begin
                next_lower = 1'b1;
            end
        end

        next_limits = limits;
        if (i_reg_req.wr && (i_reg_req.addr == SQF_LIMIT_ADDR)) begin
            next_limits = i_reg_req.wdata;
        end

        next_rvalid = i_reg_req.rd;
        next_rdata = '0;
        if (i_reg_req.rd) begin
            case (i_reg_req.addr)
                SQF_LIMIT_ADDR: begin
                    next_rdata = limits;
                end
                SQF_READ_ADDR: begin
                    if (pop) begin
                        next_rdata = {{(SQF_DATA_W-SQF_SAMPLE_W){1'b0}},
                            mem[rd_ptr].data};
                    end else begin
                        next_rdata = {{(SQF_DATA_W-SQF_SAMPLE_W){1'b0}},
                            SQF_READ_RESET};
                    end
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_sample;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            limits <= SQF_LIMIT_RESET;
            o_reg_rdata <= '0;
            o_reg_rvalid <= 1'b0;
            o_empty_flag <= SQF_EMPTY_RESET;
            o_empty_irq <= SQF_EMPTY_RESET;
            o_upper_limit_hit <= 1'b0;
            o_lower_limit_hit <= 1'b0;
            o_full <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            limits <= next_limits;
            o_reg_rdata <= next_rdata;
            o_reg_rvalid <= next_rvalid;
            o_empty_flag <= next_empty;
            o_empty_irq <= next_empty;
            o_upper_limit_hit <= next_upper;
            o_lower_limit_hit <= next_lower;
            o_full <= next_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_data_read;
        i_reg_req.rd && (i_reg_req.addr == SQF_READ_ADDR)
            && (count != '0) && i_queue_enable && !i_queue_clear;
    endsequence

    sequence s_enabled_push;
        push && cmp_en;
    endsequence

    property p_empty_disabled;
        @(posedge i_sys_clk) disable iff (i_reset)
        !i_queue_enable |=> o_empty_flag && (count == '0);
    endproperty
    a_empty_disabled: assert property (p_empty_disabled)
        else $error("empty not held while disabled");

    property p_empty_clear;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_queue_clear |=> o_empty_flag && !o_lower_limit_hit;
    endproperty
    a_empty_clear: assert property (p_empty_clear)
        else $error("clear did not empty the queue");

    property p_not_empty;
        @(posedge i_sys_clk) disable iff (i_reset)
        (count != '0) |-> !o_empty_flag;
    endproperty
    a_not_empty: assert property (p_not_empty)
        else $error("empty set with entries stored");

    property p_irq_follows;
        @(posedge i_sys_clk) disable iff (i_reset)
        o_empty_irq == o_empty_flag;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("empty interrupt differs from flag");

    property p_no_compare;
        @(posedge i_sys_clk) disable iff (i_reset)
        (push && !cmp_en && !pop && !flush) |=>
            $stable(o_upper_limit_hit) && $stable(o_lower_limit_hit);
    endproperty
    a_no_compare: assert property (p_no_compare)
        else $error("flag moved for channel without compare");

    property p_upper_hit;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_enabled_push ##0 (cmp_val >= sqf_upper(limits))
            |=> o_upper_limit_hit && !o_empty_flag;
    endproperty
    a_upper_hit: assert property (p_upper_hit)
        else $error("upper limit hit not set");

    property p_lower_hit;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_enabled_push ##0 (cmp_val <= sqf_lower(limits))
            |=> o_lower_limit_hit;
    endproperty
    a_lower_hit: assert property (p_lower_hit)
        else $error("lower limit hit not set");

    property p_limit_write;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_reg_req.wr && (i_reg_req.addr == SQF_LIMIT_ADDR))
            |=> limits == $past(i_reg_req.wdata);
    endproperty
    a_limit_write: assert property (p_limit_write)
        else $error("limit register write lost");

    property p_flags_on_empty;
        @(posedge i_sys_clk) disable iff (i_reset)
        o_empty_flag |-> !o_lower_limit_hit && !o_upper_limit_hit;
    endproperty
    a_flags_on_empty: assert property (p_flags_on_empty)
        else $error("limit flag kept while empty");

    property p_read_pop;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_data_read ##0 !push |=> o_reg_rvalid
            && (count == $past(count) - CW'(1))
            && (o_reg_rdata[SQF_SAMPLE_W-1:0] == $past(mem[rd_ptr].data));
    endproperty
    a_read_pop: assert property (p_read_pop)
        else $error("data port read did not pop oldest entry");
endmodule

// File: verif/sqf_host.sv
`timescale 1ns/1ns
module sqf_host
    import sqf_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Register port answer
    input wire logic [sqf_pkg::SQF_DATA_W-1:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    // Register port request
    output sqf_pkg::sqf_reg_req_s o_reg_req
);
    initial o_reg_req = '0;

    // Read pulse, data taken the cycle after
    task automatic rd(input logic [SQF_ADDR_W-1:0] a,
                      output logic [SQF_DATA_W-1:0] d);
        @(posedge i_sys_clk);
        o_reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: '0};
        @(posedge i_sys_clk);
        o_reg_req.rd <= 1'b0;
        #1;
        d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 'x;
    endtask

    task automatic wr(input logic [SQF_ADDR_W-1:0] a,
                      input logic [SQF_DATA_W-1:0] v);
        @(posedge i_sys_clk);
        o_reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge i_sys_clk);
        o_reg_req.wr <= 1'b0;
    endtask
endmodule

// File: verif/sample_queue_flags_readout_bench.sv
`timescale 1ns/1ns
module sample_queue_flags_readout_bench;
    import sqf_pkg::*;
    localparam int DEPTH = 8;
    logic clk = 0, rst = 1, en = 0, clr = 0, sv = 0;
    logic [15:0] cen = '0;
    sqf_sample_s smp = '0;
    sqf_reg_req_s req;
    logic [SQF_DATA_W-1:0] rdata, d;
    logic rvalid, empty, irq, up, lo, full;
    int failures = 0, comparisons = 0;

    always #5 clk = ~clk;

    sqf_queue #(.DEPTH(DEPTH), .CHANNELS(16)) dut_u (.i_sys_clk(clk),
        .i_reset(rst), .i_queue_enable(en), .i_queue_clear(clr),
        .i_per_channel_compare_enable(cen), .i_sample_valid(sv),
        .i_sample(smp), .i_reg_req(req), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_empty_flag(empty), .o_empty_irq(irq),
        .o_upper_limit_hit(up), .o_lower_limit_hit(lo), .o_full(full));
    sqf_host host_u (.i_sys_clk(clk), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid), .o_reg_req(req));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic flags(logic e, logic u, logic l);
        chk("empty", {23'h0, e}, {23'h0, empty});
        chk("irq", {23'h0, e}, {23'h0, irq});
        chk("upper", {23'h0, u}, {23'h0, up});
        chk("lower", {23'h0, l}, {23'h0, lo});
    endtask

    task automatic push(logic [3:0] c, logic [15:0] v);
        @(posedge clk);
        sv <= 1'b1;
        smp <= '{chan: c, data: v};
        @(posedge clk);
        sv <= 1'b0;
        #1;
    endtask

    task automatic pulse_clear();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        flags(1'b1, 1'b0, 1'b0);
        chk("full", 24'h0, {23'h0, full});
        host_u.rd(SQF_LIMIT_ADDR, d);
        chk("limits", 24'hFFF000, d);
        host_u.rd(8'h20, d);
        chk("unmapped", 24'h000000, d);
        push(4'h0, 16'h1234);
        flags(1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_order();
        host_u.wr(SQF_LIMIT_ADDR, 24'h800100);
        host_u.wr(SQF_READ_ADDR, 24'h123456);
        host_u.rd(SQF_LIMIT_ADDR, d);
        chk("limits", 24'h800100, d);
        @(posedge clk);
        en <= 1'b1;
        pulse_clear();
        flags(1'b1, 1'b0, 1'b0);
        for (int i = 0; i <= DEPTH; i++) push(4'h0, 16'h8000 + i[15:0]);
        flags(1'b0, 1'b0, 1'b0);
        chk("full", 24'h1, {23'h0, full});
        for (int i = 0; i < DEPTH; i++) begin
            host_u.rd(SQF_READ_ADDR, d);
            chk("data", 24'h8000 + 24'(i), d);
        end
        flags(1'b1, 1'b0, 1'b0);
        chk("full", 24'h0, {23'h0, full});
        host_u.rd(SQF_READ_ADDR, d);
        chk("empty read", 24'h000000, d);
    endtask

    task automatic t_limits();
        @(posedge clk);
        cen <= 16'h0004;
        push(4'h2, 16'h4000);
        flags(1'b0, 1'b0, 1'b0);
        push(4'h2, 16'h8000);
        flags(1'b0, 1'b1, 1'b0);
        push(4'h2, 16'h100F);
        flags(1'b0, 1'b1, 1'b1);
        pulse_clear();
        flags(1'b1, 1'b0, 1'b0);
        push(4'h2, 16'h0FFF);
        host_u.rd(SQF_READ_ADDR, d);
        chk("data", 24'h000FFF, d);
        flags(1'b1, 1'b0, 1'b0);
        push(4'h2, 16'h7FF0);
        flags(1'b0, 1'b0, 1'b0);
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        #1;
        flags(1'b1, 1'b0, 1'b0);
        chk("full", 24'h0, {23'h0, full});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        flags(1'b1, 1'b0, 1'b0);
        host_u.rd(SQF_LIMIT_ADDR, d);
        chk("limits", 24'hFFF000, d);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_order();
        t_limits();
        results();
    end
endmodule
